// [core/pwt_defs.svh]
// Register indices, field positions, reset values and codes of the PWM timer clock/irq block.
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PWT_IDX_CLK0 16'h5068
`define PWT_IDX_CLK1 16'h5069
`define PWT_IDX_CTL0 16'h5400
`define PWT_IDX_TC0 16'h5402
`define PWT_IDX_CCCTL0 16'h5404
`define PWT_IDX_CCA0 16'h5406
`define PWT_IDX_CCB0 16'h5408
`define PWT_IDX_IEN0 16'h540A
`define PWT_IDX_IFLG0 16'h540C
`define PWT_IDX_CTL1 16'h5420
`define PWT_IDX_TC1 16'h5422
`define PWT_IDX_CCCTL1 16'h5424
`define PWT_IDX_CCA1 16'h5426
`define PWT_IDX_CCB1 16'h5428
`define PWT_IDX_IEN1 16'h542A
`define PWT_IDX_IFLG1 16'h542C

// ----------------------------------------------------------------------------
// Clock control fields and interrupt flag positions
// ----------------------------------------------------------------------------
`define PWT_SHARED_BIT 1
`define PWT_F_CMPA 0
`define PWT_F_CMPB 1
`define PWT_F_CAPA 2
`define PWT_F_CAPB 3
`define PWT_F_CAPAOW 4
`define PWT_F_CAPBOW 5

// ----------------------------------------------------------------------------
// Reset values and division codes
// ----------------------------------------------------------------------------
`define PWT_CLK_RST 8'h00
`define PWT_FLAG_RST 6'h00
`define PWT_DIV_MAX_FAST 4'hE
`define PWT_DIV_MAX_SLOW 4'h8
`define PWT_DIV_REGULATED_256HZ_CLOCK 4'h9

`endif

// [core/pwt_pkg.sv]
// Types shared by the PWM timer clock/irq block.
package pwt_pkg;
	typedef enum logic [1:0] {
		PWT_SRC_FAST_B = 2'b00,
		PWT_SRC_SLOW = 2'b01,
		PWT_SRC_FAST_A = 2'b10,
		PWT_SRC_EXT = 2'b11
	} pwt_src_e;

	typedef struct packed {
		logic [3:0] div;
		pwt_src_e src;
		logic shared;
		logic gate;
	} pwt_clkctl_s;

	typedef logic [5:0] pwt_flags_t;
endpackage : pwt_pkg

// [core/pwt_clk_if.sv]
// Interface carrying source ticks and settings into one channel's clock divider.
`timescale 1ns/1ps
`default_nettype none
interface pwt_clk_if;
	logic [3:0] src_tick;
	logic regulated_256hz_clock_tick;
	pwt_pkg::pwt_clkctl_s ctl;
	logic count_tick;

	modport ctrl (output src_tick, output regulated_256hz_clock_tick, output ctl, input count_tick);
	modport div (input src_tick, input regulated_256hz_clock_tick, input ctl, output count_tick);
endinterface : pwt_clk_if
`default_nettype wire

// [core/pwt_clkdiv.sv]
// Count clock selection, division and gating for one timer channel.
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.svh"
module pwt_clkdiv (
	input wire logic clk,
	input wire logic rst,
	pwt_clk_if.div cif
);
	// ------------------------------------------------------------------------
	// Source selection and divider
	// ------------------------------------------------------------------------
	function automatic logic [13:0] pwt_div_mask(input logic [3:0] code);
		logic [14:0] one;
		one = 15'h0001 << code;
		return 14'(one - 15'h0001);
	endfunction : pwt_div_mask

	logic [13:0] cnt_q;
	logic tick_q;
	wire is_slow = (cif.ctl.src == pwt_pkg::PWT_SRC_SLOW);
	wire is_ext = (cif.ctl.src == pwt_pkg::PWT_SRC_EXT);
	wire use_regulated_256hz_clock = is_slow && (cif.ctl.div == `PWT_DIV_REGULATED_256HZ_CLOCK);
	// Reserved codes produce no count clock at all, rather than a guessed rate.
	wire code_ok = is_ext ? 1'b1 : is_slow ? (cif.ctl.div <= `PWT_DIV_REGULATED_256HZ_CLOCK) :
		(cif.ctl.div <= `PWT_DIV_MAX_FAST);
	wire src_edge = use_regulated_256hz_clock ? cif.regulated_256hz_clock_tick : cif.src_tick[cif.ctl.src];
	wire [13:0] mask = (is_ext || use_regulated_256hz_clock) ? 14'h0000 : pwt_div_mask(cif.ctl.div);
	wire tick_d = cif.ctl.gate && code_ok && src_edge && ((cnt_q & mask) == mask);

	// The prescaler restarts while gated, so the first period after enabling is full.
	always_ff @(posedge clk) begin
		if (rst || !cif.ctl.gate) begin
			cnt_q <= 14'h0000;
		end else if (src_edge) begin
			cnt_q <= cnt_q + 14'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_d;
		end
	end

	assign cif.count_tick = tick_q;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	a_gate_blocks_tick: assert property (@(posedge clk) disable iff (rst)
		!cif.ctl.gate |=> !cif.count_tick)
		else $error("count tick while count clock gate is off");
	a_reserved_code_silent: assert property (@(posedge clk) disable iff (rst)
		(!is_ext && cif.ctl.div == 4'hF) |=> !cif.count_tick)
		else $error("count tick with reserved division code");
	a_div_by_two: assert property (@(posedge clk) disable iff (rst)
		(cif.ctl.gate && !is_slow && !is_ext && cif.ctl.div == 4'h1 && $stable(cif.ctl)
		&& src_edge && !cnt_q[0]) |=> !cif.count_tick)
		else $error("divide by two ticked on even source edge");
	c_div_tick: cover property (@(posedge clk) disable iff (rst)
		cif.count_tick && cif.ctl.div != 4'h0);
endmodule : pwt_clkdiv
`default_nettype wire

// [core/pwt_top.sv]
// PWM timer count clock selection and interrupt flag/enable logic, two channels, APB slave.
//
// Functional notes
// - Capture B event while capture B flag is set raises the B overwrite flag.
// - B overwrite request reaches the controller only when its enable is 1; resets 0.
// - Overwrite flag sets regardless of whether capture B was read.
// - Any set flag with matching enable asserts the channel interrupt request.
// - Writing 1 clears a flag; writing 0 leaves it.
// - Bits 7..4 select the internal source divider; reset 0 means undivided.
// - Fast oscillators divide by 2 to the code, codes 0 to 14; 15 reserved.
// - Slow oscillator codes 0 to 8 divide; code 9 selects regulated 256 Hz.
// - Bits 3..2 pick source: fast B, slow, fast A, external pin.
// - Channel 0 bit 1 sets shared clock mode; channel 1 bit 1 reads 0.
// - Bit 0 gates the count clock; reset value 0 blocks it.
// - Shared mode feeds channel 0 count clock to every channel.
// - Each channel has one interrupt line for all its causes.
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.svh"
module pwt_top #(
	parameter int ADDR_W = 18
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fast_oscillator_a,
	input wire logic fast_oscillator_b,
	input wire logic slow_oscillator,
	input wire logic regulated_256hz_clock,
	input wire logic [1:0] external_count_clock_pin,
	input wire logic [1:0] compare_a_event,
	input wire logic [1:0] compare_b_event,
	input wire logic [1:0] capture_a_event,
	input wire logic [1:0] capture_b_event,
	output logic [1:0] count_enable,
	output logic shared_clock_mode,
	output logic [1:0] irq_to_interrupt_controller,
	output logic irq
);
	// ------------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------------
	if (ADDR_W < 18) begin : g_addr_chk
		$error("ADDR_W must be at least 18 to reach every register");
	end

	// ------------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------------
	// Order: fast B, slow, fast A, regulated 256 Hz, external pin 0, external pin 1.
	wire [5:0] pins = {external_count_clock_pin, regulated_256hz_clock, fast_oscillator_a,
		slow_oscillator, fast_oscillator_b};
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] sync3_q;
	// Oscillators faster than half of clk alias; this block is meant for slow sources.
	wire [5:0] pin_edge = sync2_q & ~sync3_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
			sync3_q <= 6'h00;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	function automatic logic pwt_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction : pwt_hit

	logic [7:0] clkctl_q [2];
	pwt_pkg::pwt_flags_t ien_q [2];
	pwt_pkg::pwt_flags_t flags_q [2];
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	wire [1:0] sel_clk = {pwt_hit(paddr, `PWT_IDX_CLK1), pwt_hit(paddr, `PWT_IDX_CLK0)};
	wire [1:0] sel_ien = {pwt_hit(paddr, `PWT_IDX_IEN1), pwt_hit(paddr, `PWT_IDX_IEN0)};
	wire [1:0] sel_iflg = {pwt_hit(paddr, `PWT_IDX_IFLG1), pwt_hit(paddr, `PWT_IDX_IFLG0)};
	// Counter, comparator and capture registers live elsewhere; here they read as zero.
	wire sel_other = pwt_hit(paddr, `PWT_IDX_CTL0) || pwt_hit(paddr, `PWT_IDX_TC0) ||
		pwt_hit(paddr, `PWT_IDX_CCCTL0) || pwt_hit(paddr, `PWT_IDX_CCA0) ||
		pwt_hit(paddr, `PWT_IDX_CCB0) || pwt_hit(paddr, `PWT_IDX_CTL1) ||
		pwt_hit(paddr, `PWT_IDX_TC1) || pwt_hit(paddr, `PWT_IDX_CCCTL1) ||
		pwt_hit(paddr, `PWT_IDX_CCA1) || pwt_hit(paddr, `PWT_IDX_CCB1);
	wire mapped = (|sel_clk) || (|sel_ien) || (|sel_iflg) || sel_other;
	wire setup = psel && !penable;
	// Only byte lane 0 holds implemented bits; the upper lanes are reserved.
	wire wr_en = psel && penable && pready_q && pwrite && pstrb[0];

	wire [31:0] rdata_d =
		({32{sel_clk[0]}} & {24'h000000, clkctl_q[0]}) |
		({32{sel_clk[1]}} & {24'h000000, clkctl_q[1]}) |
		({32{sel_ien[0]}} & {26'h0, ien_q[0]}) |
		({32{sel_ien[1]}} & {26'h0, ien_q[1]}) |
		({32{sel_iflg[0]}} & {26'h0, flags_q[0]}) |
		({32{sel_iflg[1]}} & {26'h0, flags_q[1]});

	// Read data is caught at the setup edge so the access phase never waits.
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				prdata_q <= pwrite ? 32'h00000000 : rdata_d;
				pslverr_q <= !mapped;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q && pready_q;

	// ------------------------------------------------------------------------
	// Channels: clock control, divider, flags and enables
	// ------------------------------------------------------------------------
	logic [1:0] tick;

	for (genvar i = 0; i < 2; i++) begin : g_ch
		pwt_clk_if cif();
		pwt_pkg::pwt_flags_t ev;
		pwt_pkg::pwt_flags_t clr;
		pwt_pkg::pwt_flags_t flags_d;
		logic [7:0] clk_wmask;

		// Channel 1 has no shared-mode bit; it stays zero whatever is written.
		assign clk_wmask = (i == 0) ? 8'hFF : 8'hFD;

		always_ff @(posedge clk) begin
			if (rst) begin
				clkctl_q[i] <= `PWT_CLK_RST;
				ien_q[i] <= `PWT_FLAG_RST;
			end else if (wr_en && sel_clk[i]) begin
				clkctl_q[i] <= pwdata[7:0] & clk_wmask;
			end else if (wr_en && sel_ien[i]) begin
				ien_q[i] <= pwdata[5:0];
			end
		end

		assign cif.src_tick = {pin_edge[4 + i], pin_edge[2], pin_edge[1], pin_edge[0]};
		assign cif.regulated_256hz_clock_tick = pin_edge[3];
		assign cif.ctl = pwt_pkg::pwt_clkctl_s'(clkctl_q[i]);
		assign tick[i] = cif.count_tick;

		pwt_clkdiv u_div (
			.clk(clk),
			.rst(rst),
			.cif(cif.div)
		);

		// Shared mode hands channel 0's prepared clock to every counter.
		assign count_enable[i] = shared_clock_mode ? tick[0] : tick[i];

		// Overwrite is judged on the stored capture flag only, never on a read.
		assign ev[`PWT_F_CMPA] = compare_a_event[i];
		assign ev[`PWT_F_CMPB] = compare_b_event[i];
		assign ev[`PWT_F_CAPA] = capture_a_event[i];
		assign ev[`PWT_F_CAPB] = capture_b_event[i];
		assign ev[`PWT_F_CAPAOW] = capture_a_event[i] && flags_q[i][`PWT_F_CAPA];
		assign ev[`PWT_F_CAPBOW] = capture_b_event[i] && flags_q[i][`PWT_F_CAPB];
		assign clr = (wr_en && sel_iflg[i]) ? pwdata[5:0] : `PWT_FLAG_RST;
		// A new event in the clearing cycle survives the clear.
		assign flags_d = (flags_q[i] & ~clr) | ev;

		always_ff @(posedge clk) begin
			if (rst) begin
				flags_q[i] <= `PWT_FLAG_RST;
			end else begin
				flags_q[i] <= flags_d;
			end
		end

		assign irq_to_interrupt_controller[i] = |(flags_q[i] & ien_q[i]);

		// --------------------------------------------------------------------
		// Checks
		// --------------------------------------------------------------------
		a_ovw_sets_flag: assert property (@(posedge clk) disable iff (rst)
			(capture_b_event[i] && flags_q[i][`PWT_F_CAPB]) |=> flags_q[i][`PWT_F_CAPBOW])
			else $error("capture B overwrite flag not set");
		a_ovw_needs_flag: assert property (@(posedge clk) disable iff (rst)
			$rose(flags_q[i][`PWT_F_CAPBOW]) |-> $past(flags_q[i][`PWT_F_CAPB])
			&& $past(capture_b_event[i]))
			else $error("overwrite flag set without prior capture B flag");
		a_ovw_irq_gate: assert property (@(posedge clk) disable iff (rst)
			(flags_q[i][`PWT_F_CAPBOW] && !ien_q[i][`PWT_F_CAPBOW]
			&& (flags_q[i][4:0] & ien_q[i][4:0]) == 5'h00)
			|-> !irq_to_interrupt_controller[i])
			else $error("overwrite request passed while disabled");
		a_flag_raises_irq: assert property (@(posedge clk) disable iff (rst)
			(ev != 6'h00 && (ev & ien_q[i]) != 6'h00 && !(wr_en && sel_ien[i]))
			|=> irq_to_interrupt_controller[i])
			else $error("enabled event did not raise the channel interrupt");
		a_w1c_clears: assert property (@(posedge clk) disable iff (rst)
			(wr_en && sel_iflg[i] && pwdata[`PWT_F_CMPA] && !ev[`PWT_F_CMPA])
			|=> !flags_q[i][`PWT_F_CMPA])
			else $error("write of one did not clear the flag");
		a_w0_keeps: assert property (@(posedge clk) disable iff (rst)
			(wr_en && sel_iflg[i])
			|=> (($past(flags_q[i]) & ~$past(pwdata[5:0]) & ~flags_q[i]) == 6'h00))
			else $error("write of zero cleared a flag");
		c_ovw_irq: cover property (@(posedge clk) disable iff (rst)
			$rose(flags_q[i][`PWT_F_CAPBOW]) ##1 irq_to_interrupt_controller[i]);
	end

	assign shared_clock_mode = clkctl_q[0][`PWT_SHARED_BIT];
	assign irq = |irq_to_interrupt_controller;

	// ------------------------------------------------------------------------
	// Block-level checks
	// ------------------------------------------------------------------------
	a_ch1_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && sel_clk[1]) |=> !prdata[`PWT_SHARED_BIT])
		else $error("channel 1 reserved bit reads nonzero");
	a_shared_route: assert property (@(posedge clk) disable iff (rst)
		(shared_clock_mode && $stable(clkctl_q[0]) && g_ch[0].cif.count_tick)
		|-> count_enable == 2'b11)
		else $error("shared mode did not feed every channel");
	a_reset_quiet: assert property (@(posedge clk)
		$fell(rst) |-> (count_enable == 2'b00 && !irq && !shared_clock_mode))
		else $error("outputs active right after reset");
	a_apb_answer: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable) |=> pready)
		else $error("access phase not answered in one cycle");
	c_shared_tick: cover property (@(posedge clk) disable iff (rst)
		shared_clock_mode && count_enable[1]);
	c_unmapped: cover property (@(posedge clk) disable iff (rst) pslverr);
	c_irq_clear: cover property (@(posedge clk) disable iff (rst) $fell(irq));
endmodule : pwt_top
`default_nettype wire

// [verif/pwt_partner.sv]
// Far-side model: oscillator and external count clock sources feeding the timer block.
`timescale 1ns/1ps
`default_nettype none
module pwt_partner (
	input wire logic clk,
	output logic [5:0] src
);
	// Sources stand still low between bursts so no stray edge reaches the synchronisers.
	initial begin
		src = 6'h00;
	end

	// Each edge stays high four cycles and low four, inside the slave's sampling limit.
	task automatic burst(input int sel, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			src[sel] <= 1'b1;
			repeat (4) @(posedge clk);
			src[sel] <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask : burst
endmodule : pwt_partner
`default_nettype wire

// [verif/pwm_timer_clock_and_irq_test.sv]
// Self-checking testbench of the timer count clock and interrupt block.
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.svh"
module pwm_timer_clock_and_irq_test;
	typedef struct {logic [15:0] idx; logic [3:0] sb; logic [31:0] wd; logic [31:0] rd; logic e;} pwt_row_s;
	typedef struct {int ch; logic [7:0] ctl; int sel; int n; int e0; int e1;} pwt_crow_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [17:0] paddr = 18'h00000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic [7:0] ev = 8'h00;
	wire logic [5:0] src;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] count_enable;
	logic [1:0] irq_lines;
	logic shared_clock_mode;
	logic irq;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int tests_run = 0;
	int cnt0 = 0;
	int cnt1 = 0;
	pwt_row_s rows[7] = '{'{`PWT_IDX_CLK0, 4'hF, 32'hF7, 32'hF7, 1'b0},
		'{`PWT_IDX_CLK0, 4'hE, 32'h00, 32'hF7, 1'b0}, '{`PWT_IDX_CLK1, 4'hF, 32'hFF, 32'hFD, 1'b0},
		'{`PWT_IDX_IEN0, 4'hF, 32'hFF, 32'h3F, 1'b0}, '{`PWT_IDX_IEN1, 4'hF, 32'h15, 32'h15, 1'b0},
		'{`PWT_IDX_CCB0, 4'hF, 32'h1234, 32'h00, 1'b0}, '{16'h5070, 4'hF, 32'h01, 32'h00, 1'b1}};
	pwt_crow_s crows[10] = '{'{0, 8'h21, 0, 8, 2, 0}, '{0, 8'h15, 1, 6, 3, 0},
		'{0, 8'h95, 5, 3, 3, 0}, '{0, 8'h19, 2, 4, 2, 0}, '{1, 8'h3D, 4, 3, 0, 3},
		'{0, 8'h20, 0, 4, 0, 0}, '{0, 8'hF1, 0, 4, 0, 0}, '{0, 8'h03, 0, 3, 3, 3},
		'{0, 8'h0D, 3, 3, 3, 0}, '{0, 8'hA5, 1, 3, 0, 0}};

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (count_enable[0] === 1'b1) cnt0 <= cnt0 + 1;
		if (count_enable[1] === 1'b1) cnt1 <= cnt1 + 1;
	end

	pwt_top #(.ADDR_W(18)) i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fast_oscillator_a(src[2]),
		.fast_oscillator_b(src[0]), .slow_oscillator(src[1]), .regulated_256hz_clock(src[5]),
		.external_count_clock_pin(src[4:3]), .compare_a_event(ev[1:0]),
		.compare_b_event(ev[3:2]), .capture_a_event(ev[5:4]), .capture_b_event(ev[7:6]),
		.count_enable(count_enable), .shared_clock_mode(shared_clock_mode),
		.irq_to_interrupt_controller(irq_lines), .irq(irq));

	pwt_partner i_far (.clk(clk), .src(src));

	// ----------------------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask : check

	task automatic apb(input logic w, input logic [15:0] idx, input logic [3:0] sb,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		pstrb <= sb;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends this wait, so a slave that never answers fails the run.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b1, idx, 4'hF, d);
	endtask : wr

	task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 4'hF, 32'h0);
		check(what, rd, exp);
	endtask : rd_chk

	task automatic pulse(input int k, input int ch);
		@(posedge clk);
		ev[k * 2 + ch] <= 1'b1;
		@(posedge clk);
		ev <= 8'h00;
	endtask : pulse

	task automatic results;
		if (fail_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	// ----------------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------------
	initial begin
		logic [15:0] fi;
		logic [15:0] ei;
		int n0;
		int n1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("irq after reset", {31'h0, irq}, 32'h0);
		rd_chk("clk0 reset", `PWT_IDX_CLK0, 32'h0);
		rd_chk("ien0 reset", `PWT_IDX_IEN0, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].idx, rows[i].sb, rows[i].wd);
			rd_chk("register row", rows[i].idx, rows[i].rd);
			check("row error", {31'h0, err}, {31'h0, rows[i].e});
		end
		check("shared mode", {31'h0, shared_clock_mode}, 32'h1);
		wr(`PWT_IDX_CLK0, 32'h0);
		wr(`PWT_IDX_CLK1, 32'h0);
		wr(`PWT_IDX_IEN0, 32'h0);
		wr(`PWT_IDX_IEN1, 32'h0);
		for (int ch = 0; ch < 2; ch++) begin
			fi = ch ? `PWT_IDX_IFLG1 : `PWT_IDX_IFLG0;
			ei = ch ? `PWT_IDX_IEN1 : `PWT_IDX_IEN0;
			wr(fi, 32'h3F);
			pulse(3, ch);
			rd_chk("capture b flag", fi, 32'h08);
			pulse(3, ch);
			rd_chk("capture b overwrite", fi, 32'h28);
			check("irq masked", {30'h0, irq_lines}, 32'h0);
			wr(ei, 32'h20);
			@(negedge clk);
			check("irq line", {30'h0, irq_lines}, ch ? 32'h2 : 32'h1);
			check("irq out", {31'h0, irq}, 32'h1);
			wr(fi, 32'h08);
			rd_chk("flag kept", fi, 32'h20);
			wr(fi, 32'h20);
			@(negedge clk);
			check("irq withdrawn", {30'h0, irq_lines}, 32'h0);
			pulse(3, ch);
			rd_chk("capture b data", ch ? `PWT_IDX_CCB1 : `PWT_IDX_CCB0, 32'h0);
			wr(fi, 32'h08);
			pulse(3, ch);
			rd_chk("no overwrite after clear", fi, 32'h08);
			wr(fi, 32'h08);
			for (int k = 0; k < 3; k++) begin
				wr(ei, 32'h1 << k);
				pulse(k, ch);
				rd_chk("event flag", fi, 32'h1 << k);
				check("event irq", {31'h0, irq_lines[ch]}, 32'h1);
				wr(fi, 32'h1 << k);
			end
			wr(ei, 32'h0);
			pulse(2, ch);
			pulse(2, ch);
			rd_chk("capture a overwrite", fi, 32'h14);
			wr(fi, 32'h3F);
		end
		// A reset in mid-run must drop pending flags and the request with them.
		wr(`PWT_IDX_IEN0, 32'h08);
		pulse(3, 0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("irq after second reset", {31'h0, irq}, 32'h0);
		rd_chk("flags after reset", `PWT_IDX_IFLG0, 32'h0);
		repeat (3) @(posedge clk);
		foreach (crows[i]) begin
			wr(crows[i].ch ? `PWT_IDX_CLK1 : `PWT_IDX_CLK0, {24'h0, crows[i].ctl});
			n0 = cnt0;
			n1 = cnt1;
			i_far.burst(crows[i].sel, crows[i].n);
			repeat (10) @(posedge clk);
			check("ch0 ticks", cnt0 - n0, crows[i].e0);
			check("ch1 ticks", cnt1 - n1, crows[i].e1);
			wr(crows[i].ch ? `PWT_IDX_CLK1 : `PWT_IDX_CLK0, 32'h0);
		end
		results();
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule : pwm_timer_clock_and_irq_test
`default_nettype wire
